// ---- shared/mgc_regs.svh ----
// register offsets, field positions, reset values and codes of the mode command decoder
`ifndef MGC_REGS_SVH
`define MGC_REGS_SVH

// avalon register byte offsets
`define MGC_OFS_CTRL 4'h0
`define MGC_OFS_MODE 4'h4
`define MGC_OFS_STAT 4'h8

// control register fields
`define MGC_CTRL_GUARD_BIT 0
`define MGC_CTRL_RESET 1'h0

// mode codes, five bits
`define MGC_MODE_INIT 5'h00
`define MGC_MODE_FLASH 5'h01
`define MGC_MODE_NREQ 5'h02
`define MGC_MODE_NORMAL 5'h03
`define MGC_MODE_LP_BIT 4

// spi frame layout
`define MGC_FRAME_BITS 5'h10
`define MGC_MODE_ADDR 5'h0E
`define MGC_TOP_READ 2'h0
`define MGC_TOP_WRITE 2'h1
`define MGC_TOP_STATUS 2'h3
`define MGC_OFF_PREFIX 2'h3
`define MGC_CODE_NREQ 4'h2

// fixed status byte returned in bits 15..8
`define MGC_FIX_STATUS 8'h00

// lfsr seed for the key source
`define MGC_LFSR_SEED 8'hA5

`endif

// ---- shared/mgc_pkg.sv ----
// types shared by the mode command decoder
package mgc_pkg;

    typedef logic [4:0] mgc_mode_t;

    // decoded fields of one received 16-bit frame
    typedef struct packed {
        logic [1:0] top;
        logic [4:0] addr;
        logic sel;
        logic b7;
        logic [3:0] code_lo;
        logic [2:0] low;
    } mgc_frame_t;

    // device state as software sees it
    typedef struct packed {
        logic key_valid;
        logic guard;
        logic [2:0] key;
        logic debug;
        logic safe_off;
        mgc_mode_t mode;
    } mgc_stat_t;

endpackage : mgc_pkg

// ---- logic/mgc_pin_sync.sv ----
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module mgc_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // shift chain, first stage feeds only the second
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // per bit agreement filter
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    sync_out[i] <= INIT[i];
                end else if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    endgenerate

endmodule : mgc_pin_sync

// ---- logic/mgc_mode_decoder.sv ----
// mode register global command decoder with spi slave and avalon register port
// What this block does
// - key guard enabled only in init mode
// - normal mode read commands return the key
// - key sits on response bits two to zero
// - unguarded 0x5C60 enters regulator off low power
// - 1D00 returns mode, exits debug, keeps safe
// - 1D80 returns mode, releases safe output
// - DD00 exits debug, reports safe and debug
// - DD80 keeps debug, releases safe, reports both
// - response carries fixed status and mode code
// - five bit mode code, top bit low power
// - safe status bit one means driver off
// - debug status bit one means debug active
// - pending wake flag wakes right after entry
`timescale 1ns/1ps
`include "mgc_regs.svh"
module mgc_mode_decoder (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    input wire logic wake_pending_in,
    input wire logic debug_strap_in,
    output logic safe_drive_out,
    output logic debug_active_out,
    output mgc_pkg::mgc_mode_t mode_out,
    output logic low_power_regulator_off_out,
    output logic timed_wakeup_out,
    output logic cyclic_sense_out
);

    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic sclk_d_r;
    logic cs_n_d_r;
    logic [4:0] cnt_r;
    logic [15:0] rx_r;
    logic [15:0] tx_r;
    logic [2:0] cand_key_r;
    logic [2:0] key_r;
    logic key_valid_r;
    logic guard_r;
    logic [7:0] lfsr_r;
    logic strap_done_r;
    logic frame_done;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic avs_req;
    logic avs_take;
    logic force_mode;
    logic is_read;
    logic is_wr;
    logic is_lp;
    logic key_ok;
    logic lp_enter;
    mgc_pkg::mgc_frame_t fr;
    mgc_pkg::mgc_stat_t stat;
    logic [15:0] resp_nxt;
    logic [31:0] rdata_nxt;

    // pins are asynchronous to the core clock
    mgc_pin_sync #(
        .WIDTH(3),
        .INIT(3'h2)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .pin_in({spi_sclk_in, spi_cs_n_in, spi_mosi_in}),
        .sync_out({sclk_s, cs_n_s, mosi_s})
    );

    // edge detection on filtered pins
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    assign cs_fall = cs_n_d_r && !cs_n_s;
    assign sclk_rise = !cs_n_s && sclk_s && !sclk_d_r;
    assign sclk_fall = !cs_n_s && !sclk_s && sclk_d_r;
    assign frame_done = !cs_n_d_r && cs_n_s && (cnt_r == `MGC_FRAME_BITS);

    // frame field split and command classes
    assign fr = mgc_pkg::mgc_frame_t'(rx_r);
    assign is_read = frame_done && fr.sel && (fr.addr == `MGC_MODE_ADDR)
        && ((fr.top == `MGC_TOP_READ) || (fr.top == `MGC_TOP_STATUS));
    // mode writes carry bit eight low, so only top bits and address select them
    assign is_wr = frame_done && (fr.addr == `MGC_MODE_ADDR) && (fr.top == `MGC_TOP_WRITE);
    assign is_lp = is_wr && (fr.b7 || (fr.code_lo[3:2] == `MGC_OFF_PREFIX));
    assign key_ok = !guard_r || (key_valid_r && (fr.low == ~key_r));
    assign lp_enter = is_lp && (mode_out == `MGC_MODE_NORMAL) && key_ok;

    // free running key source
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            lfsr_r <= `MGC_LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end

    // response word: fixed status, mode, key
    always_comb begin
        resp_nxt = {`MGC_FIX_STATUS, mode_out, lfsr_r[2:0]};
    end

    // serial bit counter and receive shifter
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cnt_r <= 5'h00;
            rx_r <= 16'h0000;
        end else if (cs_fall) begin
            cnt_r <= 5'h00;
        end else if (sclk_rise) begin
            rx_r <= {rx_r[14:0], mosi_s};
            if (cnt_r != 5'h11) begin
                cnt_r <= cnt_r + 5'h01;
            end
        end
    end

    // response word load and status patch once top bits are known
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tx_r <= 16'h0000;
            cand_key_r <= 3'h0;
        end else if (cs_fall) begin
            tx_r <= resp_nxt;
            cand_key_r <= lfsr_r[2:0];
        end else if (sclk_rise && cnt_r == 5'h01 && {rx_r[0], mosi_s} == `MGC_TOP_STATUS) begin
            tx_r[2:0] <= {1'b0, !safe_drive_out, debug_active_out};
        end
    end

    // miso: msb at select, next bit on each falling clock
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            spi_miso_out <= 1'b0;
        end else if (cs_fall) begin
            spi_miso_out <= resp_nxt[15];
        end else if (sclk_fall && cnt_r != 5'h00 && cnt_r < `MGC_FRAME_BITS) begin
            spi_miso_out <= tx_r[4'(15 - cnt_r)];
        end
    end

    // key issue on a normal mode read, consumed by low power entry
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            key_r <= 3'h0;
            key_valid_r <= 1'b0;
        end else if (is_read && fr.top == `MGC_TOP_READ && mode_out == `MGC_MODE_NORMAL) begin
            key_r <= cand_key_r;
            key_valid_r <= 1'b1;
        end else if (lp_enter) begin
            key_valid_r <= 1'b0;
        end
    end

    // avalon request handshake, one wait cycle then waitrequest low
    assign avs_req = avs_read_in || avs_write_in;
    assign avs_take = avs_req && !avs_waitrequest_out;
    assign force_mode = avs_take && avs_write_in && (avs_address_in == `MGC_OFS_MODE);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (avs_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // read data mux, unmapped offsets read zero
    assign stat = '{key_valid: key_valid_r, guard: guard_r, key: key_r, debug: debug_active_out,
        safe_off: !safe_drive_out, mode: mode_out};
    always_comb begin
        unique case (avs_address_in)
            `MGC_OFS_CTRL: rdata_nxt = {31'h00000000, guard_r};
            `MGC_OFS_MODE: rdata_nxt = {27'h0000000, mode_out};
            `MGC_OFS_STAT: rdata_nxt = {20'h00000, stat};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            avs_readdata_out <= 32'h00000000;
        end else if (avs_read_in && avs_waitrequest_out) begin
            avs_readdata_out <= rdata_nxt;
        end
    end

    // guard enable writable only while in init mode
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            guard_r <= `MGC_CTRL_RESET;
        end else if (avs_take && avs_write_in && avs_address_in == `MGC_OFS_CTRL
            && mode_out == `MGC_MODE_INIT) begin
            guard_r <= avs_writedata_in[`MGC_CTRL_GUARD_BIT];
        end
    end

    // current mode
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            mode_out <= `MGC_MODE_INIT;
        end else if (force_mode) begin
            mode_out <= avs_writedata_in[4:0];
        end else if (mode_out[`MGC_MODE_LP_BIT] && wake_pending_in) begin
            mode_out <= `MGC_MODE_NREQ;
        end else if (lp_enter) begin
            mode_out <= {1'b1, fr.code_lo};
        end else if (is_wr && mode_out[`MGC_MODE_LP_BIT] && !fr.b7 && fr.code_lo == `MGC_CODE_NREQ) begin
            mode_out <= `MGC_MODE_NREQ;
        end
    end

    // low power selection details
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            low_power_regulator_off_out <= 1'b0;
            timed_wakeup_out <= 1'b0;
            cyclic_sense_out <= 1'b0;
        end else if (lp_enter) begin
            low_power_regulator_off_out <= !fr.b7;
            timed_wakeup_out <= fr.b7 ? fr.code_lo[3] : fr.code_lo[1];
            cyclic_sense_out <= fr.b7 ? fr.code_lo[2] : fr.code_lo[0];
        end
    end

    // fail-safe driver, active from reset until released
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            safe_drive_out <= 1'b1;
        end else if (is_read && fr.b7) begin
            safe_drive_out <= 1'b0;
        end
    end

    // debug state caught from strap after reset, left on command
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            strap_done_r <= 1'b0;
            debug_active_out <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            debug_active_out <= debug_strap_in;
        end else if (is_read && !fr.b7) begin
            debug_active_out <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_safe_release: assert property (is_read && fr.b7 |=> !safe_drive_out)
        else $error("safe output not released");
    a_safe_keep: assert property (is_read && !fr.b7 && safe_drive_out |=> safe_drive_out)
        else $error("safe output changed on keep command");
    a_debug_exit: assert property (strap_done_r && is_read && !fr.b7 |=> !debug_active_out)
        else $error("debug not left");
    a_debug_keep: assert property (is_read && fr.b7 && debug_active_out |=> debug_active_out)
        else $error("debug dropped on keep command");
    a_guard_init: assert property ($changed(guard_r) |-> $past(mode_out) == `MGC_MODE_INIT)
        else $error("guard changed outside init");
    a_key_reject: assert property (is_lp && !key_ok && !force_mode && !mode_out[4]
        |=> $stable(mode_out))
        else $error("mode changed on bad key");
    a_key_issue: assert property (is_read && fr.top == 2'h0 && mode_out == `MGC_MODE_NORMAL
        |=> key_valid_r && key_r == $past(cand_key_r))
        else $error("key not issued");
    a_resp_word: assert property (cs_fall |=> tx_r[15:3] == {`MGC_FIX_STATUS, $past(mode_out)}
        && tx_r[2:0] == $past(lfsr_r[2:0]))
        else $error("response word wrong");
    a_wake_lp: assert property (mode_out[4] && wake_pending_in && !force_mode
        |=> mode_out == `MGC_MODE_NREQ)
        else $error("pending wake did not wake");
    a_lp_entry: assert property (lp_enter && !wake_pending_in && !force_mode
        |=> mode_out[4] ##1 !key_valid_r)
        else $error("low power not entered");
    a_avs_answer: assert property (avs_req && avs_waitrequest_out |-> ##1 !avs_waitrequest_out)
        else $error("bus answer late");

    c_lp_enter: cover property (lp_enter && guard_r);
    c_safe_off: cover property (is_read && fr.top == 2'h3 && fr.b7);
    c_key_bad: cover property (is_lp && !key_ok);

endmodule : mgc_mode_decoder

// ---- bench/mgc_spi_host.sv ----
// spi host model, drives frames msb first and collects the response
`timescale 1ns/1ps
module mgc_spi_host (
    input wire logic core_clk_in,
    input wire logic spi_miso_in,
    output logic spi_sclk_out,
    output logic spi_cs_n_out,
    output logic spi_mosi_out
);
    // idle: clock low, select high
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : wt

    // one 16-bit frame, 8 core cycles per half period
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge core_clk_in);
        spi_cs_n_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi_out <= tx[i];
            wt(8);
            spi_sclk_out <= 1'b1;
            rx[i] = spi_miso_in; // taken at the rising edge
            wt(8);
            spi_sclk_out <= 1'b0;
        end
        wt(8);
        spi_cs_n_out <= 1'b1;
        spi_mosi_out <= ~tx[0]; // released line shows no stale bit
        wt(8);
    endtask : xfer
endmodule : mgc_spi_host

// ---- bench/tb.sv ----
// self-checking bench of the mode command decoder
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    logic sclk, cs_n, mosi, miso;
    logic wake = 1'b0;
    logic strap = 1'b0;
    logic safe, dbg, regoff, twu, cyc;
    mgc_pkg::mgc_mode_t mode;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [15:0] r;
    logic [31:0] q;
    logic [2:0] key;

    always #50 core_clk = ~core_clk;

    mgc_mode_decoder i_mgc_mode_decoder (.core_clk_in(core_clk), .srst_in(srst), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .wake_pending_in(wake), .debug_strap_in(strap), .safe_drive_out(safe),
        .debug_active_out(dbg), .mode_out(mode), .low_power_regulator_off_out(regoff),
        .timed_wakeup_out(twu), .cyclic_sense_out(cyc));

    mgc_spi_host i_mgc_spi_host (.core_clk_in(core_clk), .spi_miso_in(miso), .spi_sclk_out(sclk),
        .spi_cs_n_out(cs_n), .spi_mosi_out(mosi));

    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // avalon cycle held until waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] o);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        @(posedge core_clk);
        while (wreq !== 1'b0) @(posedge core_clk);
        o = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rst(input logic s);
        srst <= 1'b1;
        strap <= s;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : rst

    task automatic t_reset();
        rst(1'b0);
        chk("safe", safe, 1);
        chk("mode", mode, 5'h00);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("stat", q[12:0], 13'h0000);
        bus(1'b0, 4'hC, 32'h0, q);
        chk("unmapped", q, 32'h0);
    endtask : t_reset

    task automatic t_guard();
        rst(1'b0);
        bus(1'b1, 4'h0, 32'h1, q);
        bus(1'b1, 4'h4, 32'h3, q);
        bus(1'b1, 4'h0, 32'h0, q);
        bus(1'b0, 4'h8, 32'h0, q);
        chk("guard", q[10], 1);
        i_mgc_spi_host.xfer(16'h1D00, r);
        chk("resp hi", r[15:3], {8'h00, 5'h03});
        key = r[2:0];
        bus(1'b0, 4'h8, 32'h0, q);
        chk("key", q[11:7], {2'b11, key});
        i_mgc_spi_host.xfer({13'h0B8C, ~key ^ 3'h1}, r);
        chk("bad key mode", mode, 5'h03);
        i_mgc_spi_host.xfer({13'h0B8C, ~key}, r);
        chk("lp mode", mode, 5'h1C);
        chk("reg off", regoff, 1);
        i_mgc_spi_host.xfer(16'h5C10, r);
        chk("spi wake mode", mode, 5'h02);
    endtask : t_guard

    task automatic t_plain(input logic w, input logic [15:0] cmd, input logic [4:0] m, input logic [2:0] f);
        rst(1'b0);
        bus(1'b1, 4'h4, 32'h3, q);
        wake <= w;
        i_mgc_spi_host.xfer(cmd, r);
        chk("lp resp", r[15:3], {8'h00, 5'h03});
        chk("lp mode", mode, m);
        chk("lp flags", {regoff, twu, cyc}, f);
        bus(1'b0, 4'h4, 32'h0, q);
        chk("mode reg", q, {27'h0000000, m});
        wake <= 1'b0;
    endtask : t_plain

    task automatic t_safe();
        rst(1'b1);
        chk("debug", dbg, 1);
        i_mgc_spi_host.xfer(16'h1C80, r);
        chk("no bit8", {safe, dbg}, 2'b11);
        i_mgc_spi_host.xfer(16'hDD80, r);
        chk("dd80 resp", r[1:0], 2'b01);
        chk("dd80 pins", {safe, dbg}, 2'b01);
        i_mgc_spi_host.xfer(16'hDD00, r);
        chk("dd00 resp", {r[15:3], r[1:0]}, {13'h0000, 2'b11});
        chk("dd00 pins", {safe, dbg}, 2'b00);
    endtask : t_safe

    task automatic t_read_exit();
        rst(1'b1);
        i_mgc_spi_host.xfer(16'h1D00, r);
        chk("1d00 pins", {safe, dbg}, 2'b10);
        i_mgc_spi_host.xfer(16'h1D80, r);
        chk("1d80 safe", safe, 0);
    endtask : t_read_exit

    // main sequence
    initial begin
        t_reset();
        t_guard();
        t_plain(1'b0, 16'h5C60, 5'h1C, 3'b100);
        t_plain(1'b1, 16'h5C60, 5'h02, 3'b100);
        t_plain(1'b0, 16'h5C78, 5'h1F, 3'b111);
        t_plain(1'b0, 16'h5CC0, 5'h18, 3'b010);
        t_safe();
        t_read_exit();
        end_of_test();
    end
endmodule : tb
